// *** shared/ccg_pkg.sv ***
// shared constants and types of the clock generator configuration control
package ccg_pkg;

  // ----------------------------------------------------------------
  // serial slave identity and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR  = 7'h6a;
  localparam logic [1:0] CMD_ACCESS  = 2'h0;
  localparam logic [1:0] CMD_SAVE    = 2'h1;
  localparam logic [1:0] CMD_RESTORE = 2'h2;

  // ----------------------------------------------------------------
  // bit framing inside one byte slot
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_FIRST    = 4'h0;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [3:0] BIT_ACK_SLOT = 4'h8;

  // ----------------------------------------------------------------
  // configuration select pins
  // ----------------------------------------------------------------
  localparam int         SEL_W    = 3;
  localparam logic [2:0] SEL_LAST = 3'h5;
  localparam logic [2:0] SEL_RST  = 3'h0;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_GLOBAL_OFS = 8'h02;
  localparam int         BIT_POL        = 0;
  localparam int         BIT_SHUT       = 1;
  localparam logic [7:0] CFG_BASE       = 8'h10;
  localparam logic [7:0] CFG_STRIDE     = 8'h04;
  localparam logic [7:0] CFG_REF_OFS    = 8'h00;
  localparam logic [7:0] CFG_SEL_OFS    = 8'h01;
  localparam logic [7:0] CFG_PINCTL_OFS = 8'h02;
  localparam int         BIT_XBYP       = 0;
  localparam int         BIT_PRIM       = 1;
  localparam int         BIT_SM_LO      = 2;
  localparam int         BIT_SM_HI      = 3;
  localparam logic [7:0] REG_RST        = 8'h00;
  localparam logic [7:0] PTR_RST        = 8'h00;

  // ----------------------------------------------------------------
  // slave sequencer states, gray along address, command, pointer, data
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_CMD  = 3'h3,
    ST_PTR  = 3'h2,
    ST_DATA = 3'h6,
    ST_TX   = 3'h7,
    ST_HOLD = 3'h5
  } ccg_state_t;

endpackage

// *** src/ccg_link_sampler.sv ***
// serial clock domain sampler: one data bit per rising clock edge, toggle marks it
`timescale 1ns/1ps
`default_nettype none

module ccg_link_sampler (
  input  wire logic scl_clk_i,
  input  wire logic link_rst_i,
  input  wire logic sda_i,
  output logic      bit_tgl_o,
  output logic      bit_val_o
);

  typedef struct packed {
    logic tgl;
    logic val;
  } ccg_link_state_t;

  ccg_link_state_t st;
  ccg_link_state_t next_st;

  // ----------------------------------------------------------------
  // sampling
  // ----------------------------------------------------------------
  // the value stays put until the next edge, hundreds of nanoseconds away, so the
  // system side may read it once it has seen the toggle move
  always_comb begin
    next_st     = st;
    next_st.tgl = ~st.tgl;
    next_st.val = sda_i;
  end

  // the bus clock stands still between frames, so reset cannot wait for it
  always_ff @(posedge scl_clk_i or posedge link_rst_i) begin
    if (link_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bit_tgl_o = st.tgl;
  assign bit_val_o = st.val;

endmodule

`default_nettype wire

// *** src/ccg_config_ctrl.sv ***
// clock generator configuration control: serial slave, store sequencing, pin logic
`timescale 1ns/1ps
`default_nettype none
module ccg_config_ctrl #(
  parameter int         REG_COUNT = 256,
  parameter int         OUT_COUNT = 4,
  parameter logic [7:0] DEVICE_ID = 8'h5a  // arbitrary identification value
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     scl_clk_i,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_o,
  input  wire logic [ccg_pkg::SEL_W-1:0] config_select_pin_i,
  input  wire logic                     reference_choice_pin_i,
  input  wire logic                     shutdown_output_enable_pin_i,
  output logic [ccg_pkg::SEL_W-1:0]     config_index_o,
  output logic                          config_reserved_o,
  output logic                          crystal_bypass_o,
  output logic                          reference_external_o,
  output logic                          switchover_auto_o,
  output logic                          switchover_revert_o,
  output logic                          global_shutdown_o,
  output logic [OUT_COUNT-1:0]          clock_output_hiz_o,
  output logic [OUT_COUNT-1:0]          clock_output_run_o,
  output logic                          store_busy_o
);
  import ccg_pkg::*;

  localparam int IDX_W = (REG_COUNT > 1) ? $clog2(REG_COUNT) : 1;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(REG_COUNT - 1);

  typedef logic [REG_COUNT-1:0][7:0] ccg_bank_t;

  typedef struct packed {
    ccg_bank_t            regs;
    ccg_bank_t            nvm;
    ccg_state_t           state;
    logic [SEL_W-1:0]     sel_s1;
    logic [SEL_W-1:0]     sel_s2;
    logic                 reference_choice_pin_s1;
    logic                 reference_choice_pin_s2;
    logic                 sdoe_s1;
    logic                 sdoe_s2;
    logic                 scl_s1;
    logic                 scl_s2;
    logic                 scl_s3;
    logic                 sda_s1;
    logic                 sda_s2;
    logic                 sda_s3;
    logic                 tgl_s1;
    logic                 tgl_s2;
    logic                 tgl_s3;
    logic [3:0]           cnt;
    logic [7:0]           shreg;
    logic [7:0]           txbyte;
    logic [7:0]           ptr;
    logic                 ack_want;
    logic                 sda_oe;
    logic [1:0]           pend;
    logic                 pend_valid;
    logic                 copy_run;
    logic                 restoring;
    logic [IDX_W-1:0]     copy_idx;
    logic [SEL_W-1:0]     cfg_idx;
    logic                 cfg_rsv;
    logic                 xbyp;
    logic                 refext;
    logic                 swa;
    logic                 swr;
    logic                 gshut;
    logic [OUT_COUNT-1:0] hiz;
    logic [OUT_COUNT-1:0] run;
  } ccg_state_reg_t;

  ccg_state_reg_t st;
  ccg_state_reg_t next_st;

  logic       link_tgl;
  logic       link_bit;
  logic       bit_evt;
  logic       start_c;
  logic       stop_c;
  logic       fall_c;
  logic [7:0] rx_byte;
  logic [7:0] ref_reg;
  logic [7:0] sel_reg;
  logic [7:0] pinctl_reg;
  logic [7:0] glob_reg;
  logic       pin_act;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_rd(input ccg_bank_t bank, input logic [7:0] addr);
    logic [7:0] val;
    val = REG_RST;
    if (int'(addr) < REG_COUNT) begin
      val = bank[addr];
    end
    return val;
  endfunction

  function automatic logic [7:0] cfg_addr(input logic [SEL_W-1:0] idx,
                                          input logic [7:0] ofs);
    return CFG_BASE + CFG_STRIDE * {5'h00, idx} + ofs;
  endfunction

  // ----------------------------------------------------------------
  // bus clock domain
  // ----------------------------------------------------------------
  ccg_link_sampler u_link (
    .scl_clk_i  (scl_clk_i),
    .link_rst_i (sys_rst_i),
    .sda_i      (sda_i),
    .bit_tgl_o  (link_tgl),
    .bit_val_o  (link_bit)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;

    // pins pass two flops; the third stage only feeds edge detection
    next_st.sel_s1    = config_select_pin_i;
    next_st.sel_s2    = st.sel_s1;
    next_st.reference_choice_pin_s1 = reference_choice_pin_i;
    next_st.reference_choice_pin_s2 = st.reference_choice_pin_s1;
    next_st.sdoe_s1   = shutdown_output_enable_pin_i;
    next_st.sdoe_s2   = st.sdoe_s1;
    next_st.scl_s1    = scl_clk_i;
    next_st.scl_s2    = st.scl_s1;
    next_st.scl_s3    = st.scl_s2;
    next_st.sda_s1    = sda_i;
    next_st.sda_s2    = st.sda_s1;
    next_st.sda_s3    = st.sda_s2;
    next_st.tgl_s1    = link_tgl;
    next_st.tgl_s2    = st.tgl_s1;
    next_st.tgl_s3    = st.tgl_s2;

    start_c = st.scl_s2 && st.scl_s3 && st.sda_s3 && !st.sda_s2;
    stop_c  = st.scl_s2 && st.scl_s3 && !st.sda_s3 && st.sda_s2;
    fall_c  = st.scl_s3 && !st.scl_s2;
    bit_evt = st.tgl_s2 != st.tgl_s3;
    rx_byte = {st.shreg[6:0], link_bit};

    // -------- bit and byte handling --------
    if (bit_evt && st.state != ST_IDLE) begin
      if (st.cnt == BIT_ACK_SLOT) begin
        next_st.cnt      = BIT_FIRST;
        next_st.ack_want = 1'b0;
        if (!st.ack_want && st.state == ST_TX) begin
          if (link_bit) begin
            next_st.state = ST_IDLE;  // refused byte ends the read
          end else begin
            next_st.txbyte = reg_rd(st.regs, st.ptr);
            next_st.ptr    = st.ptr + 8'h01;
          end
        end
      end else begin
        next_st.cnt   = st.cnt + 4'h1;
        next_st.shreg = rx_byte;
        if (st.cnt == BIT_LAST) begin
          case (st.state)
            ST_ADDR: begin
              // no answer while the store is being copied
              if (rx_byte[7:1] == SLAVE_ADDR && !st.copy_run) begin
                next_st.ack_want = 1'b1;
                if (rx_byte[0]) begin
                  next_st.state  = ST_TX;
                  next_st.txbyte = DEVICE_ID;
                end else begin
                  next_st.state = ST_CMD;
                end
              end else begin
                next_st.state = ST_IDLE;
              end
            end
            ST_CMD: begin
              next_st.ack_want = 1'b1;
              case (rx_byte[1:0])  // upper six bits ignored
                CMD_ACCESS: begin
                  next_st.state = ST_PTR;
                end
                CMD_SAVE, CMD_RESTORE: begin
                  next_st.pend       = rx_byte[1:0];
                  next_st.pend_valid = 1'b1;
                  next_st.state      = ST_HOLD;
                end
                default: begin
                  next_st.ack_want = 1'b0;
                  next_st.state    = ST_IDLE;
                end
              endcase
            end
            ST_PTR: begin
              next_st.ack_want = 1'b1;
              next_st.ptr      = rx_byte;
              next_st.state    = ST_DATA;
            end
            ST_DATA: begin
              next_st.ack_want = 1'b1;
              if (int'(st.ptr) < REG_COUNT) begin
                next_st.regs[st.ptr] = rx_byte;
              end
              next_st.ptr = st.ptr + 8'h01;
            end
            default: begin
              next_st.ack_want = 1'b0;
            end
          endcase
        end
      end
    end

    // -------- change the data line only while the clock is low --------
    if (fall_c) begin
      if (st.cnt == BIT_ACK_SLOT && st.ack_want) begin
        next_st.sda_oe = 1'b1;
      end else if (st.state == ST_TX && st.cnt != BIT_ACK_SLOT) begin
        next_st.sda_oe = ~st.txbyte[3'h7 - st.cnt[2:0]];
      end else begin
        next_st.sda_oe = 1'b0;
      end
    end

    // -------- frame boundaries win over bit handling --------
    if (start_c) begin
      next_st.state      = ST_ADDR;  // repeated start keeps the pointer
      next_st.cnt        = BIT_FIRST;
      next_st.ack_want   = 1'b0;
      next_st.sda_oe     = 1'b0;
      next_st.pend_valid = 1'b0;
    end else if (stop_c) begin
      next_st.state      = ST_IDLE;
      next_st.cnt        = BIT_FIRST;
      next_st.ack_want   = 1'b0;
      next_st.sda_oe     = 1'b0;
      next_st.pend_valid = 1'b0;
      if (st.pend_valid && st.state == ST_HOLD) begin
        next_st.copy_run  = 1'b1;  // copy begins only after stop
        next_st.restoring = (st.pend == CMD_RESTORE);
        next_st.copy_idx  = '0;
      end
    end

    // -------- store copy, one byte per cycle --------
    if (st.copy_run) begin
      if (st.restoring) begin
        next_st.regs[st.copy_idx] = st.nvm[st.copy_idx];
      end else begin
        next_st.nvm[st.copy_idx] = st.regs[st.copy_idx];
      end
      next_st.copy_idx = st.copy_idx + 1'b1;
      if (st.copy_idx == IDX_LAST) begin
        next_st.copy_run = 1'b0;
      end
    end

    // -------- configuration choice --------
    if (st.sel_s2 <= SEL_LAST) begin
      next_st.cfg_idx = st.sel_s2;
      next_st.cfg_rsv = 1'b0;
    end else begin
      next_st.cfg_rsv = 1'b1;  // reserved code keeps the last valid choice
    end

    ref_reg    = reg_rd(st.regs, cfg_addr(st.cfg_idx, CFG_REF_OFS));
    sel_reg    = reg_rd(st.regs, cfg_addr(st.cfg_idx, CFG_SEL_OFS));
    pinctl_reg = reg_rd(st.regs, cfg_addr(st.cfg_idx, CFG_PINCTL_OFS));
    glob_reg   = reg_rd(st.regs, REG_GLOBAL_OFS);

    next_st.xbyp   = ref_reg[BIT_XBYP];
    next_st.refext = ref_reg[BIT_PRIM] ^ st.reference_choice_pin_s2;
    next_st.swa    = ref_reg[BIT_SM_HI];
    next_st.swr    = ref_reg[BIT_SM_HI] & ref_reg[BIT_SM_LO];

    // -------- output gating: shutdown, then select, then pin control --------
    pin_act       = glob_reg[BIT_POL] ? st.sdoe_s2 : ~st.sdoe_s2;
    next_st.gshut = glob_reg[BIT_SHUT] & st.sdoe_s2;
    for (int i = 0; i < OUT_COUNT; i++) begin
      if (next_st.gshut) begin
        next_st.hiz[i] = 1'b0;
        next_st.run[i] = 1'b0;
      end else if (!sel_reg[i]) begin
        next_st.hiz[i] = 1'b1;
        next_st.run[i] = 1'b0;
      end else begin
        next_st.hiz[i] = 1'b0;
        next_st.run[i] = ~(pinctl_reg[i] & pin_act);
      end
    end

    // -------- reset: the store is non-volatile and survives --------
    if (sys_rst_i) begin
      next_st           = '0;
      next_st.nvm       = st.nvm;
      next_st.state     = ST_IDLE;
      next_st.scl_s1    = 1'b1;
      next_st.scl_s2    = 1'b1;
      next_st.scl_s3    = 1'b1;
      next_st.sda_s1    = 1'b1;
      next_st.sda_s2    = 1'b1;
      next_st.sda_s3    = 1'b1;
      next_st.ptr       = PTR_RST;
      next_st.cfg_idx   = SEL_RST;
      next_st.copy_run  = 1'b1;  // automatic restore after power-up
      next_st.restoring = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sda_o                = 1'b0;
  assign sda_oe_o             = st.sda_oe;
  assign config_index_o       = st.cfg_idx;
  assign config_reserved_o    = st.cfg_rsv;
  assign crystal_bypass_o     = st.xbyp;
  assign reference_external_o = st.refext;
  assign switchover_auto_o    = st.swa;
  assign switchover_revert_o  = st.swr;
  assign global_shutdown_o    = st.gshut;
  assign clock_output_hiz_o   = st.hiz;
  assign clock_output_run_o   = st.run;
  assign store_busy_o         = st.copy_run;

endmodule

`default_nettype wire

// *** tb/ccg_config_ctrl_monitor.sv ***
// assertion checker on the configuration control ports
`timescale 1ns/1ps
`default_nettype none
module ccg_config_ctrl_monitor #(
  parameter int REG_COUNT = 256,
  parameter int OUT_COUNT = 4
) (
  input wire logic                        sys_clk_i,
  input wire logic                        sys_rst_i,
  input wire logic                        scl_clk_i,
  input wire logic                        sda_oe_o,
  input wire logic [ccg_pkg::SEL_W-1:0]   config_select_pin_i,
  input wire logic                        shutdown_output_enable_pin_i,
  input wire logic [ccg_pkg::SEL_W-1:0]   config_index_o,
  input wire logic                        config_reserved_o,
  input wire logic                        switchover_auto_o,
  input wire logic                        switchover_revert_o,
  input wire logic                        global_shutdown_o,
  input wire logic [OUT_COUNT-1:0]        clock_output_hiz_o,
  input wire logic [OUT_COUNT-1:0]        clock_output_run_o,
  input wire logic                        store_busy_o
);
  import ccg_pkg::*;
  // ----
  // copy window, slack for the start and stop detection
  // ----
  localparam int COPY_MIN = REG_COUNT - 4;
  localparam int COPY_MAX = REG_COUNT + 4;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // five stable samples cover two sync stages and the output register
  chk_index_follow: assert property ($stable(config_select_pin_i) [*5] ##0
    (config_select_pin_i <= SEL_LAST) |-> config_index_o == config_select_pin_i)
    else $error("index does not follow select pins");
  chk_reserved_flag: assert property ($stable(config_select_pin_i) [*5] ##0
    (config_select_pin_i > SEL_LAST) |-> config_reserved_o)
    else $error("reserved select code not flagged");
  chk_reserved_hold: assert property (config_reserved_o |-> $stable(config_index_o))
    else $error("index moved on a reserved code");
  chk_revert_auto: assert property (switchover_revert_o |-> switchover_auto_o)
    else $error("revertive mode without automatic mode");
  chk_shutdown_quiet: assert property (global_shutdown_o |->
    clock_output_hiz_o == '0 && clock_output_run_o == '0)
    else $error("output active in global shutdown");
  chk_pin_low_live: assert property ($stable(shutdown_output_enable_pin_i) [*5] ##0
    !shutdown_output_enable_pin_i |-> !global_shutdown_o)
    else $error("global shutdown with pin low");
  chk_hiz_exclusive: assert property (|clock_output_run_o |->
    (clock_output_hiz_o & clock_output_run_o) == '0)
    else $error("output both high impedance and running");
  chk_sda_low_phase: assert property ($changed(sda_oe_o) |-> !scl_clk_i)
    else $error("data line moved while clock high");
  chk_busy_no_ack: assert property (store_busy_o |-> !sda_oe_o)
    else $error("acknowledge during copy");
  chk_copy_length: assert property ($rose(store_busy_o) |->
    ##[COPY_MIN:COPY_MAX] $fell(store_busy_o))
    else $error("copy length wrong");
endmodule
`default_nettype wire

// *** tb/ccg_i2c_master.sv ***
// serial bus master model: clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module ccg_i2c_master (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  // half period of twelve system cycles, well above the three sampling stages of the slave
  localparam int H = 300;
  localparam int Q = 100;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // data moves a third into the low phase, clear of the falling edge
  task automatic clk_bit(input logic b, output logic r);
    #Q sda_low_o = !b;
    #(H - Q) scl_o = 1'b1;
    #H r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start();
    #Q sda_low_o = 1'b0;
    #(H - Q) scl_o = 1'b1;
    #H sda_low_o = 1'b1;
    #H scl_o = 1'b0;
  endtask
  task automatic stop();
    #Q sda_low_o = 1'b1;
    #(H - Q) scl_o = 1'b1;
    #H sda_low_o = 1'b0;
    #H;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(output logic [7:0] b, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      b[i] = r;
    end
    clk_bit(nack, r);
  endtask
endmodule
`default_nettype wire

// *** tb/ccg_config_ctrl_bench.sv ***
// self-checking bench of the configuration control block
`timescale 1ns/1ps
`default_nettype none
module ccg_config_ctrl_bench;
  import ccg_pkg::*;
  localparam int         REG_COUNT = 256;
  localparam int         OUT_COUNT = 4;
  localparam logic [7:0] DEV_ID    = 8'h5a;  // arbitrary identification value
  logic       sys_clk_i, sys_rst_i, scl, sda, sda_low, sda_o, sda_oe_o, choice, sd_pin;
  logic       rsv, byp, ext, auto_sw, revert, gshut, busy;
  logic [2:0] sel, idx;
  logic [3:0] hiz, run;
  int         errors = 0;
  int         tests_run = 0;
  logic [7:0] ref_tab [6] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h0c, 8'h06};
  // open drain line with pull-up
  assign sda = !sda_low && (!sda_oe_o || sda_o);
  ccg_i2c_master ccg_i2c_master_i (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));
  ccg_config_ctrl #(.REG_COUNT(REG_COUNT), .OUT_COUNT(OUT_COUNT), .DEVICE_ID(DEV_ID))
  ccg_config_ctrl_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .scl_clk_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .config_select_pin_i(sel),
    .reference_choice_pin_i(choice), .shutdown_output_enable_pin_i(sd_pin),
    .config_index_o(idx), .config_reserved_o(rsv), .crystal_bypass_o(byp),
    .reference_external_o(ext), .switchover_auto_o(auto_sw), .switchover_revert_o(revert),
    .global_shutdown_o(gshut), .clock_output_hiz_o(hiz), .clock_output_run_o(run),
    .store_busy_o(busy));
  // ----
  // shared helpers
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic ack;
    ccg_i2c_master_i.wbyte(b, ack);
    check(8'(ack), 8'(exp_ack), "acknowledge");
  endtask
  task automatic wr_regs(input logic [7:0] ptr, input logic [7:0] d[$]);
    ccg_i2c_master_i.start();
    send({SLAVE_ADDR, 1'b0}, 1'b1);
    send(8'hfc, 1'b1);
    send(ptr, 1'b1);
    foreach (d[i]) send(d[i], 1'b1);
    ccg_i2c_master_i.stop();
  endtask
  task automatic rd_regs(input logic [7:0] ptr, input logic [7:0] exp[$]);
    logic [7:0] b;
    ccg_i2c_master_i.start();
    send({SLAVE_ADDR, 1'b0}, 1'b1);
    send(8'h00, 1'b1);
    send(ptr, 1'b1);
    ccg_i2c_master_i.start();
    send({SLAVE_ADDR, 1'b1}, 1'b1);
    ccg_i2c_master_i.rbyte(b, 1'b0);
    check(b, DEV_ID, "id byte");
    foreach (exp[i]) begin
      ccg_i2c_master_i.rbyte(b, i == exp.size() - 1);
      check(b, exp[i], "read data");
    end
    ccg_i2c_master_i.stop();
  endtask
  task automatic command(input logic [7:0] a, input logic [7:0] c, input logic ok);
    ccg_i2c_master_i.start();
    send(a, a == {SLAVE_ADDR, 1'b0});
    if (a == {SLAVE_ADDR, 1'b0}) send(c, ok);
    ccg_i2c_master_i.stop();
  endtask
  // no traffic until the copy is over
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(negedge sys_clk_i);
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge sys_clk_i);
      n++;
    end
    check(8'(n < 1000), 8'h01, "copy finished");
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_config();
    logic [7:0] q[$];
    for (int k = 0; k < 6; k++) q = {q, ref_tab[k], k ? 8'h0f : 8'h07, k ? 8'h00 : 8'h05, 8'h00};
    wr_regs(CFG_BASE, q);
    wr_regs(REG_GLOBAL_OFS, {8'h00});
    rd_regs(CFG_BASE, q);
    for (int k = 0; k < 8; k++) begin
      for (int c = 0; c < 2; c++) begin
        sel = 3'(k);
        choice = c[0];
        repeat (6) @(negedge sys_clk_i);
        check(8'(rsv), 8'(k > 5), "reserved");
        check(8'(idx), (k > 5) ? 8'h05 : 8'(k), "index");
        if (k < 6) begin
          check(8'(byp), 8'(ref_tab[k][0]), "bypass");
          check(8'(ext), 8'(ref_tab[k][1] ^ c[0]), "reference");
          check(8'(auto_sw), 8'(ref_tab[k][3]), "auto");
          check(8'(revert), 8'(&ref_tab[k][3:2]), "revert");
        end
      end
    end
    sel = 3'h0;
    $display("test config done");
  endtask
  task automatic t_outputs();
    logic gs, act;
    for (int v = 0; v < 4; v++) begin
      wr_regs(REG_GLOBAL_OFS, {8'(v)});
      for (int p = 0; p < 2; p++) begin
        @(negedge sys_clk_i);
        sd_pin = p[0];
        repeat (6) @(negedge sys_clk_i);
        gs = v[1] & p[0];
        act = p[0] == v[0];
        check(8'(gshut), 8'(gs), "shutdown");
        check(8'(hiz), gs ? 8'h00 : 8'h08, "hiz");
        check(8'(run), gs ? 8'h00 : (act ? 8'h02 : 8'h07), "run");
      end
    end
    $display("test outputs done");
  endtask
  task automatic t_store();
    command({7'h6b, 1'b0}, 8'h00, 1'b0);
    wr_regs(REG_GLOBAL_OFS, {8'h01});
    command({SLAVE_ADDR, 1'b0}, 8'hfd, 1'b1);
    check(8'(busy), 8'h01, "save busy");
    wait_idle();
    wr_regs(REG_GLOBAL_OFS, {8'h02});
    command({SLAVE_ADDR, 1'b0}, 8'h03, 1'b0);
    command({SLAVE_ADDR, 1'b0}, 8'h06, 1'b1);
    wait_idle();
    rd_regs(REG_GLOBAL_OFS, {8'h01});
    @(negedge sys_clk_i);
    sys_rst_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    wait_idle();
    rd_regs(REG_GLOBAL_OFS, {8'h01});
    rd_regs(CFG_BASE, {8'h00, 8'h07, 8'h05});
    $display("test store done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    // a true rising edge, so the bus clock side is reset before its first toggle
    sys_rst_i = 1'b0;
    #1;
    sys_rst_i = 1'b1;
    sel = 3'h0;
    choice = 1'b0;
    sd_pin = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    wait_idle();
    t_config();
    t_outputs();
    t_store();
    end_sim();
  end
  initial begin
    #2ms;
    errors++;
    end_sim();
  end
endmodule
bind ccg_config_ctrl ccg_config_ctrl_monitor #(.REG_COUNT(REG_COUNT), .OUT_COUNT(OUT_COUNT))
ccg_config_ctrl_monitor_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .scl_clk_i(scl_clk_i), .sda_oe_o(sda_oe_o), .config_select_pin_i(config_select_pin_i),
  .shutdown_output_enable_pin_i(shutdown_output_enable_pin_i),
  .config_index_o(config_index_o), .config_reserved_o(config_reserved_o),
  .switchover_auto_o(switchover_auto_o), .switchover_revert_o(switchover_revert_o),
  .global_shutdown_o(global_shutdown_o), .clock_output_hiz_o(clock_output_hiz_o),
  .clock_output_run_o(clock_output_run_o), .store_busy_o(store_busy_o));
`default_nettype wire
